// file: aperture_delay_pkg.sv
// constants and types for the aperture delay register bank
package aperture_delay_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned REG_W  = 24;
	localparam logic [11:0] CAL_RESULT_ADDR = 12'h2B2;
	localparam logic [11:0] DELAY_ADJ_ADDR  = 12'h2B5;
	localparam logic [23:0] DELAY_ADJ_RESET = 24'h000000;
	localparam int unsigned DONE_BIT   = 17;
	localparam int unsigned INV_BIT    = 16;
	localparam int unsigned COARSE_LSB = 8;
	localparam int unsigned COARSE_W   = 8;
	localparam int unsigned FINE_W     = 8;
	// ramp: one step per this many clock cycles
	localparam int unsigned RAMP_PERIOD   = 384;
	localparam logic [7:0]  RAMP_STEP_SLOW = 8'h01;
	localparam logic [7:0]  RAMP_STEP_FAST = 8'h04;

	typedef struct packed {
		logic       invert;
		logic [7:0] coarse;
		logic [7:0] fine;
	} delay_s;
endpackage

// file: aperture_delay_adjust_regs.sv
// register bank for calibration result and manual aperture delay
// Notes on behaviour
// - done flag at bit 17 set only while calibration enabled and finished
// - computed 17-bit delay shown in status bits 16:0, valid when done
// - computed value: bit 16 inversion, 15:8 coarse, 7:0 fine
// - delay register bit 16 set inverts the sampling clock
// - with calibration off, bits 15:8 give applied coarse step
// - with calibration off, bits 7:0 give applied fine step
// - fine field may change any time, applied directly, glitch free
// - calibration enable rising edge starts calibration sequence
// - calibration enabled means engine delay applied once done (last delay held until then), manual register ignored
// - ramp enable makes applied coarse step gradually toward written value
`timescale 1ns/1ps
module aperture_delay_adjust_regs #(
	parameter int unsigned RAMP_CYCLES = aperture_delay_pkg::RAMP_PERIOD
) (
	// clock and reset
	input  wire logic                                 core_clk,
	input  wire logic                                 rst,
	// serial register port, decoded word access
	input  wire logic                                 reg_wr,
	input  wire logic [aperture_delay_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [aperture_delay_pkg::REG_W-1:0]  reg_wdata,
	output logic      [aperture_delay_pkg::REG_W-1:0]  reg_rdata,
	// neighbouring control bits
	input  wire logic                                 sysref_cal_enable,
	input  wire logic                                 ramp_enable,
	input  wire logic                                 ramp_fast,
	// calibration engine
	output logic                                      cal_start,
	input  wire logic                                 cal_finished,
	input  wire aperture_delay_pkg::delay_s            cal_delay,
	// applied delay to the clock path
	output aperture_delay_pkg::delay_s                 applied_delay
);
	// refuse ramp periods the step counter cannot hold
	if (RAMP_CYCLES < 1 || RAMP_CYCLES > 65535) begin : g_bad_ramp
		$error("RAMP_CYCLES out of range");
	end

	// manual register value after reset
	localparam aperture_delay_pkg::delay_s MANUAL_RESET =
		aperture_delay_pkg::delay_s'(aperture_delay_pkg::DELAY_ADJ_RESET[aperture_delay_pkg::INV_BIT:0]);

	// host-written delay register
	aperture_delay_pkg::delay_s              manual_r;
	aperture_delay_pkg::delay_s              manual_nxt;

	// delay driven into the clock path
	aperture_delay_pkg::delay_s              applied_r;
	aperture_delay_pkg::delay_s              applied_nxt;

	// coarse value walking toward the register
	logic [aperture_delay_pkg::COARSE_W-1:0] ramp_coarse_r;
	logic [aperture_delay_pkg::COARSE_W-1:0] ramp_coarse_nxt;

	// cycles since the last ramp step
	logic [15:0]                             ramp_cnt_r;
	logic [15:0]                             ramp_cnt_nxt;

	// enable as seen one cycle ago
	logic                                    cal_en_d_r;

	// calibration finished since the last start
	logic                                    done_r;
	logic                                    done_nxt;

	// delay reported by the engine
	aperture_delay_pkg::delay_s              result_r;
	aperture_delay_pkg::delay_s              result_nxt;

	// address decode
	wire logic sel_result = (reg_addr == aperture_delay_pkg::CAL_RESULT_ADDR);
	wire logic sel_delay  = (reg_addr == aperture_delay_pkg::DELAY_ADJ_ADDR);
	wire logic wr_delay   = reg_wr && sel_delay;

	// ramp timing
	wire logic ramp_tick  = (ramp_cnt_r == 16'(RAMP_CYCLES - 1));
	wire logic ramp_hold  = ramp_tick || !ramp_enable;

	// ramp step size and distance to the target
	wire logic [7:0] step    = ramp_fast ? aperture_delay_pkg::RAMP_STEP_FAST : aperture_delay_pkg::RAMP_STEP_SLOW;
	wire logic [7:0] target  = manual_r.coarse;
	wire logic [7:0] diff_up = target - ramp_coarse_r;
	wire logic [7:0] diff_dn = ramp_coarse_r - target;
	wire logic       go_up   = ramp_tick && (target > ramp_coarse_r);
	wire logic       go_dn   = ramp_tick && (target < ramp_coarse_r);
	wire logic [7:0] up_val  = (diff_up > step) ? 8'(ramp_coarse_r + step) : target;
	wire logic [7:0] dn_val  = (diff_dn > step) ? 8'(ramp_coarse_r - step) : target;

	// calibration state seen by the applied delay
	wire logic cal_ready  = sysref_cal_enable && done_r;
	wire logic cal_busy   = sysref_cal_enable && !done_r;

	wire logic done_flag  = done_r && sysref_cal_enable;

	assign cal_start = sysref_cal_enable && !cal_en_d_r;

	always_comb begin
		manual_nxt = manual_r;
		if (wr_delay) begin
			manual_nxt = aperture_delay_pkg::delay_s'(reg_wdata[aperture_delay_pkg::INV_BIT:0]);
		end
	end

	// step counter restarts each tick
	always_comb begin
		ramp_cnt_nxt = ramp_cnt_r + 16'h0001;
		if (ramp_hold) begin
			ramp_cnt_nxt = '0;
		end
	end

	always_comb begin
		ramp_coarse_nxt = ramp_coarse_r;
		if (!ramp_enable) begin
			ramp_coarse_nxt = target;
		end else if (go_up) begin
			ramp_coarse_nxt = up_val;
		end else if (go_dn) begin
			ramp_coarse_nxt = dn_val;
		end
	end

	always_comb begin
		done_nxt   = done_r;
		result_nxt = result_r;
		if (!sysref_cal_enable || cal_start) begin
			done_nxt = 1'b0;
		end else if (cal_finished) begin
			done_nxt   = 1'b1;
			result_nxt = cal_delay;
		end
	end

	always_comb begin
		applied_nxt = applied_r;
		if (cal_ready) begin
			applied_nxt = result_r;
		end else if (cal_busy) begin
			// hold the last delay until a result arrives
			applied_nxt = applied_r;
		end else begin
			applied_nxt.invert = manual_r.invert;
			applied_nxt.coarse = ramp_coarse_r;
			applied_nxt.fine   = manual_r.fine;
		end
	end

	always_comb begin
		reg_rdata = '0;
		if (sel_result) begin
			reg_rdata[aperture_delay_pkg::DONE_BIT]  = done_flag;
			reg_rdata[aperture_delay_pkg::INV_BIT:0] = result_r;
		end else if (sel_delay) begin
			reg_rdata[aperture_delay_pkg::INV_BIT:0] = manual_r;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			manual_r <= MANUAL_RESET;
		end else begin
			manual_r <= manual_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ramp_cnt_r <= '0;
		end else begin
			ramp_cnt_r <= ramp_cnt_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ramp_coarse_r <= '0;
		end else begin
			ramp_coarse_r <= ramp_coarse_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cal_en_d_r <= 1'b0;
		end else begin
			cal_en_d_r <= sysref_cal_enable;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			done_r <= 1'b0;
		end else begin
			done_r <= done_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			result_r <= '0;
		end else begin
			result_r <= result_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			applied_r <= '0;
		end else begin
			applied_r <= applied_nxt;
		end
	end

	// data output straight from its flip-flops
	assign applied_delay = applied_r;
endmodule

// file: aperture_delay_adjust_regs_sva.sv
// checker for the aperture delay register bank
`timescale 1ns/1ps
module aperture_delay_adjust_regs_sva (
	input wire logic core_clk, rst, reg_wr, sysref_cal_enable, ramp_enable, ramp_fast, cal_start, cal_finished,
	input wire logic [11:0] reg_addr,
	input wire logic [23:0] reg_wdata, reg_rdata,
	input wire aperture_delay_pkg::delay_s cal_delay, applied_delay
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_slow; !sysref_cal_enable && ramp_enable && !ramp_fast; endsequence
	sequence s_wr; reg_wr && reg_addr == 12'h2B5; endsequence
	property p_start; cal_start == $rose(sysref_cal_enable); endproperty
	a_start: assert property (p_start) else $error("bad start pulse");
	property p_done; reg_addr == 12'h2B2 && reg_rdata[17] |-> sysref_cal_enable; endproperty
	a_done: assert property (p_done) else $error("done while disabled");
	property p_res; cal_finished && sysref_cal_enable && !cal_start ##1 reg_addr == 12'h2B2 && sysref_cal_enable
		|-> reg_rdata == {7'h01, $past(cal_delay)}; endproperty
	a_res: assert property (p_res) else $error("bad result read");
	property p_man; s_wr ##0 !sysref_cal_enable && !ramp_enable ##1
		(!(reg_wr && reg_addr == 12'h2B5) && !sysref_cal_enable && !ramp_enable) [*2]
		|=> applied_delay == $past(reg_wdata[16:0], 3); endproperty
	a_man: assert property (p_man) else $error("manual delay not applied");
	property p_ign; (sysref_cal_enable && !cal_finished) [*3] ##1 sysref_cal_enable |-> $stable(applied_delay); endproperty
	a_ign: assert property (p_ign) else $error("applied moved during calibration");
	property p_unm; !(reg_addr inside {12'h2B2, 12'h2B5}) |-> reg_rdata == 24'h000000; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_rb; s_wr ##1 reg_addr == 12'h2B5 |-> reg_rdata == {7'h00, $past(reg_wdata[16:0])}; endproperty
	a_rb: assert property (p_rb) else $error("bad readback");
	property p_ramp; s_slow ##1 s_slow |-> 8'(applied_delay.coarse - $past(applied_delay.coarse)) inside {8'h00, 8'h01, 8'hFF};
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp step too large");
endmodule
bind aperture_delay_adjust_regs aperture_delay_adjust_regs_sva SVA (.*);

// file: cal_engine_model.sv
// calibration engine stand-in that finishes a fixed time after each start
`timescale 1ns/1ps
module cal_engine_model #(parameter int LAT = 6) (
	input wire logic core_clk, rst, cal_start,
	input wire aperture_delay_pkg::delay_s result,
	output logic cal_finished,
	output aperture_delay_pkg::delay_s cal_delay
);
	logic [3:0] cnt_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) cnt_r <= 4'h0;
		else cnt_r <= cal_start ? 4'(LAT) : cnt_r - 4'(cnt_r != 4'h0);
	end
	assign cal_finished = cnt_r == 4'h1;
	// result bus carries garbage outside the finish pulse
	assign cal_delay = cal_finished ? result : ~result;
endmodule

// file: aperture_delay_adjust_regs_tb_top.sv
// self-checking bench for the aperture delay register bank
`timescale 1ns/1ps
module aperture_delay_adjust_regs_tb_top;
	logic core_clk = 0, rst = 1, reg_wr = 0, sysref_cal_enable = 0, ramp_enable = 0, ramp_fast = 0, cal_start, cal_finished;
	logic [11:0] reg_addr = 12'h000;
	logic [23:0] reg_wdata = 24'h000000, reg_rdata;
	aperture_delay_pkg::delay_s cal_delay, applied_delay, cal_value = 17'h15AC3;
	int fails = 0, n_compared = 0, i;
	always #25 core_clk = ~core_clk;
	aperture_delay_adjust_regs #(.RAMP_CYCLES(4)) DUT (.*);
	cal_engine_model ENG (.core_clk, .rst, .cal_start, .result(cal_value), .cal_finished, .cal_delay);
	task automatic step(input int n); repeat (n) @(posedge core_clk); #5; endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [23:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [23:0] exp); reg_addr = a; #1 chk(reg_rdata, exp); endtask
	task automatic wr(input logic [11:0] a, input logic [23:0] d); reg_addr = a; reg_wdata = d; reg_wr = 1; step(1); reg_wr = 0; endtask
	task automatic await_applied(input logic [16:0] exp);
		for (i = 0; i < 400 && applied_delay !== exp; i++) step(1);
		chk(24'(applied_delay), 24'(exp));
		if (i == 400) summarize();
	endtask
	initial begin
		step(2);
		rst = 0;
		rd(12'h2B2, 24'h000000);
		rd(12'h2B5, 24'h000000);
		rd(12'h2B3, 24'h000000);
		$display("reset test done");
		// inversion and large coarse jumps only with enables low
		wr(12'h2B5, 24'hFF5A3C);
		rd(12'h2B5, 24'h015A3C);
		wr(12'h2B2, 24'hFFFFFF);
		step(1);
		chk(24'(applied_delay), 24'h015A3C);
		rd(12'h2B2, 24'h000000);
		wr(12'h2B5, 24'h015AFF);
		step(2);
		chk(24'(applied_delay), 24'h015AFF);
		$display("manual test done");
		sysref_cal_enable = 1;
		reg_addr = 12'h2B2;
		for (i = 0; i < 50 && reg_rdata[17] !== 1'b1; i++) step(1);
		chk(24'(reg_rdata[17]), 24'h000001);
		if (i == 50) summarize();
		rd(12'h2B2, 24'h035AC3);
		wr(12'h2B5, 24'h000000);
		step(3);
		chk(24'(applied_delay), 24'h015AC3);
		sysref_cal_enable = 0;
		reg_addr = 12'h2B2;
		#1 chk(24'(reg_rdata[17]), 24'h000000);
		await_applied(17'h00000);
		$display("calibration test done");
		ramp_enable = 1;
		for (int f = 0; f < 2; f++) begin
			ramp_fast = f[0];
			wr(12'h2B5, {8'h00, 8'h10 << (f * 2), 8'h00});
			await_applied({1'b0, 8'h10 << (f * 2), 8'h00});
		end
		$display("ramp test done");
		summarize();
	end
endmodule
